/* mrc_pkg.sv */
// package: constants, option encodings and carriers for the reset and option block
package mrc_pkg;
    // register indices; byte address is four times the index
    localparam logic [11:0] MRC_IDX_STATUS = 12'h086;
    localparam logic [11:0] MRC_IDX_OPTION = 12'h087;
    localparam logic [11:0] MRC_ADDR_STATUS = 12'h218;
    localparam logic [11:0] MRC_ADDR_OPTION = 12'h21C;
    // status bit positions
    localparam int MRC_B_CAUSE_HI = 7;
    localparam int MRC_B_CAUSE_LO = 6;
    localparam int MRC_B_FLAG_HIGH = 5;
    localparam int MRC_B_FLAG_MID = 4;
    localparam int MRC_B_CARRY = 2;
    localparam int MRC_B_DCARRY = 1;
    localparam int MRC_B_ZERO = 0;
    localparam logic [1:0] MRC_CAUSE_WDT = 2'h0;
    localparam logic [1:0] MRC_CAUSE_POR = 2'h2;
    localparam logic [1:0] MRC_CAUSE_PIN = 2'h3;
    localparam logic [10:0] MRC_OPTION_RESET = 11'h000;
    localparam logic [1:0] MRC_RESP_OKAY = 2'h0;
    localparam logic [1:0] MRC_RESP_DECERR = 2'h3;
    // divider figures
    localparam logic [4:0] MRC_DIV4 = 5'h04;
    localparam logic [4:0] MRC_DIV8 = 5'h08;
    localparam logic [4:0] MRC_DIV16 = 5'h10;
    localparam logic [4:0] MRC_SLOW_DIV = 5'h04;

    typedef enum logic [2:0] {
        MRC_CLK_internal_fast_rc = 3'h0,
        MRC_CLK_EXT_RC = 3'h1,
        MRC_CLK_XTAL_32K = 3'h2,
        MRC_CLK_XTAL_12M = 3'h3,
        MRC_CLK_XTAL_4M = 3'h4
    } mrc_clk_e;
    typedef enum logic [1:0] {MRC_FCPU_4 = 2'h0, MRC_FCPU_8 = 2'h1, MRC_FCPU_16 = 2'h2} mrc_fcpu_e;
    typedef enum logic [1:0] {MRC_WDT_ALWAYS = 2'h0, MRC_WDT_ENABLE = 2'h1, MRC_WDT_OFF = 2'h2} mrc_wdt_e;
    typedef enum logic [1:0] {
        MRC_supply_guard_low = 2'h0,
        MRC_supply_guard_mid = 2'h1,
        MRC_supply_guard_high = 2'h2,
        MRC_supply_guard_max = 2'h3
    } mrc_lvd_e;

    // option word, packed low bit last: lvd, security, pin, wdt, fcpu, clk
    typedef struct packed {
        mrc_lvd_e lvd;
        logic security;
        logic input_only_pin_mode;
        mrc_wdt_e wdt;
        mrc_fcpu_e fcpu;
        mrc_clk_e clk_src;
    } mrc_opt_s;

    // analog detector levels: high while supply is at or below the level
    typedef struct packed {
        logic below_3v6;
        logic below_2v4;
        logic below_2v0;
    } mrc_lvd_s;
endpackage : mrc_pkg

/* mrc_top.sv */
// reset sequencer, option decode and status register behind an AXI4-Lite slave
//
// Operation
// - normal mode: one instruction cycle per 4, 8 or 16 fast oscillator clocks
// - slow mode: slow RC clock divided by fixed 4, divider option ignored
// - watchdog always-on counts in power-down, green and normal operation
// - watchdog enable counts outside power-down and green; disable makes it inactive
// - reset-pin function: falling edge on the pin resets the whole system
// - general-input choice: no pin reset, pin is input-only bit, no pull-up
// - security enabled blocks read-out of the whole program memory
// - low-voltage option picks reset level 2.0V, 2.0V, 2.4V or 3.6V
// - medium enables 2.4V flag, high enables 3.6V flag; disabled flags read 0
// - reset sources: power-on, watchdog, brown-out, pin when pin option enables
// - in reset registers held initial, execution halted, PC cleared; start at 0
// - cause bits 7:6 read 00 watchdog, 10 power-on or low-voltage, 11 pin
// - cause, carry, digit carry, zero read/write; low-voltage flags read-only
// - power-up: stable supply, pin check, register init, warm-up, then run
// - pin enabled and not high at power-up keeps device in reset
// - watchdog overflow: reset, init, warm-up, restart in normal mode
// - warm-up length depends on clock source: RC short, crystal longer
// - internal RC frees both oscillator pins; ext RC frees output; crystals use both
// - any low-voltage reset clears both low-voltage flags
// - enabled flag reads 1 at or below its level, 0 above it
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module mrc_top
    import mrc_pkg::*;
#(
    parameter int INIT_CYCLES = 4,
    parameter int WARM_RC_CYCLES = 64,
    parameter int WARM_XTAL_CYCLES = 4096
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic supply_stable,
    input wire mrc_lvd_s lvd_level,
    input wire logic reset_pin,
    input wire logic wdt_overflow,
    input wire logic power_down_mode,
    input wire logic green_mode,
    input wire logic slow_mode,
    input wire logic fast_osc_tick,
    input wire logic slow_osc_tick,
    output logic system_reset,
    output logic pc_clear,
    output logic cpu_run,
    output logic cpu_cycle,
    output logic wdt_count_en,
    output logic rom_readout_block,
    output logic pin_port_bit,
    output logic pin_pullup_en,
    output logic osc_in_pin_gpio,
    output logic osc_out_pin_gpio
);
    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic supply_s;
    logic pin_s;
    mrc_lvd_s lvd_s;
    logic pin_prev_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_r <= 6'h00;
            sync2_r <= 6'h00;
            pin_prev_r <= 1'b0;
        end
        else
        begin
            sync1_r <= {supply_stable, reset_pin, lvd_level, 1'b0};
            sync2_r <= sync1_r;
            pin_prev_r <= pin_s;
        end
    end

    assign supply_s = sync2_r[5];
    assign pin_s = sync2_r[4];
    assign lvd_s = sync2_r[3:1];

    // ----------------------------------------------------------------
    // option register and decode
    // ----------------------------------------------------------------
    mrc_opt_s opt_r;
    logic pin_reset_mode;
    logic lvd_reset;
    logic pin_reset;
    logic wdt_reset;

    assign pin_reset_mode = !opt_r.input_only_pin_mode;

    function automatic logic lvd_trips(input mrc_lvd_e sel, input mrc_lvd_s lv);
        case (sel)
            MRC_supply_guard_high: lvd_trips = lv.below_2v4;
            MRC_supply_guard_max: lvd_trips = lv.below_3v6;
            default: lvd_trips = lv.below_2v0;
        endcase
    endfunction : lvd_trips

    assign lvd_reset = !supply_s || lvd_trips(opt_r.lvd, lvd_s);
    assign pin_reset = pin_reset_mode && pin_prev_r && !pin_s;
    assign wdt_reset = (opt_r.wdt != MRC_WDT_OFF) && wdt_overflow;

    // ----------------------------------------------------------------
    // reset sequencer
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        MRC_ST_POWER_UP,
        MRC_ST_PIN_CHECK,
        MRC_ST_INIT,
        MRC_ST_WARMUP,
        MRC_ST_RUN
    } mrc_state_e;

    mrc_state_e state_r;
    logic [15:0] cnt_r;
    logic [15:0] warm_last;
    logic xtal_src;

    // crystals need far longer to settle than an RC source
    assign xtal_src = (opt_r.clk_src != MRC_CLK_internal_fast_rc)
        && (opt_r.clk_src != MRC_CLK_EXT_RC);
    assign warm_last = xtal_src ? 16'(WARM_XTAL_CYCLES - 1) : 16'(WARM_RC_CYCLES - 1);

    always_ff @(posedge aclk)
    begin
        if (!aresetn || lvd_reset)
        begin
            state_r <= MRC_ST_POWER_UP;
            cnt_r <= 16'h0000;
        end
        else if (pin_reset || wdt_reset)
        begin
            // watchdog skips the pin check and goes straight to init
            state_r <= pin_reset ? MRC_ST_PIN_CHECK : MRC_ST_INIT;
            cnt_r <= 16'h0000;
        end
        else
        begin
            case (state_r)
                MRC_ST_POWER_UP: state_r <= MRC_ST_PIN_CHECK;
                MRC_ST_PIN_CHECK:
                begin
                    // in pin-reset mode stays here until the outside releases the pin high; general-input mode moves on at once
                    if (!pin_reset_mode || pin_s)
                        state_r <= MRC_ST_INIT;
                end
                MRC_ST_INIT:
                begin
                    if (cnt_r == 16'(INIT_CYCLES - 1))
                    begin
                        state_r <= MRC_ST_WARMUP;
                        cnt_r <= 16'h0000;
                    end
                    else
                        cnt_r <= cnt_r + 16'h0001;
                end
                MRC_ST_WARMUP:
                begin
                    if (cnt_r == warm_last)
                    begin
                        state_r <= MRC_ST_RUN;
                        cnt_r <= 16'h0000;
                    end
                    else
                        cnt_r <= cnt_r + 16'h0001;
                end
                default: state_r <= MRC_ST_RUN;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            system_reset <= 1'b1;
            pc_clear <= 1'b1;
            cpu_run <= 1'b0;
        end
        else
        begin
            // pc held at 0 until release so execution opens at address 0
            system_reset <= (state_r != MRC_ST_RUN) || lvd_reset || pin_reset || wdt_reset;
            pc_clear <= (state_r != MRC_ST_RUN) || lvd_reset || pin_reset || wdt_reset;
            cpu_run <= (state_r == MRC_ST_RUN) && !lvd_reset && !pin_reset && !wdt_reset;
        end
    end

    // ----------------------------------------------------------------
    // instruction cycle divider and watchdog gating
    // ----------------------------------------------------------------
    logic [4:0] div_cnt_r;
    logic [4:0] div_last;
    logic div_tick;

    // slow mode ignores the divider option altogether
    assign div_last = slow_mode ? 5'(MRC_SLOW_DIV - 5'h01)
        : (opt_r.fcpu == MRC_FCPU_16) ? 5'(MRC_DIV16 - 5'h01)
        : (opt_r.fcpu == MRC_FCPU_8) ? 5'(MRC_DIV8 - 5'h01)
        : 5'(MRC_DIV4 - 5'h01);
    assign div_tick = slow_mode ? slow_osc_tick : fast_osc_tick;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || system_reset)
        begin
            div_cnt_r <= 5'h00;
            cpu_cycle <= 1'b0;
        end
        else
        begin
            cpu_cycle <= div_tick && (div_cnt_r >= div_last);
            if (div_tick)
                div_cnt_r <= (div_cnt_r >= div_last) ? 5'h00 : div_cnt_r + 5'h01;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wdt_count_en <= 1'b0;
        else
        begin
            case (opt_r.wdt)
                MRC_WDT_ALWAYS: wdt_count_en <= 1'b1;
                MRC_WDT_ENABLE: wdt_count_en <= !power_down_mode && !green_mode;
                default: wdt_count_en <= 1'b0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin and memory options
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_port_bit <= 1'b0;
            pin_pullup_en <= 1'b0;
            rom_readout_block <= 1'b0;
            osc_in_pin_gpio <= 1'b0;
            osc_out_pin_gpio <= 1'b0;
        end
        else
        begin
            pin_port_bit <= pin_reset_mode ? 1'b0 : pin_s;
            pin_pullup_en <= pin_reset_mode;
            rom_readout_block <= opt_r.security;
            osc_in_pin_gpio <= (opt_r.clk_src == MRC_CLK_internal_fast_rc);
            osc_out_pin_gpio <= !xtal_src;
        end
    end

    // ----------------------------------------------------------------
    // status register
    // ----------------------------------------------------------------
    logic [1:0] cause_r;
    logic [2:0] alu_flags_r;
    logic flag_mid_r;
    logic flag_high_r;
    logic [7:0] status_rd;
    logic wr_fire;
    logic wr_status;
    logic wr_option;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;

    assign status_rd = {cause_r, flag_high_r, flag_mid_r, 1'b0, alu_flags_r};
    assign wr_status = wr_fire && (awaddr_r == MRC_ADDR_STATUS) && wstrb_r[0];
    assign wr_option = wr_fire && (awaddr_r == MRC_ADDR_OPTION);

    // a reset event overrides a software write in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cause_r <= MRC_CAUSE_POR;
        else if (lvd_reset)
            cause_r <= MRC_CAUSE_POR;
        else if (pin_reset)
            cause_r <= MRC_CAUSE_PIN;
        else if (wdt_reset)
            cause_r <= MRC_CAUSE_WDT;
        else if (wr_status)
            cause_r <= wdata_r[MRC_B_CAUSE_HI:MRC_B_CAUSE_LO];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || system_reset)
            alu_flags_r <= 3'h0;
        else if (wr_status)
            alu_flags_r <= wdata_r[MRC_B_CARRY:MRC_B_ZERO];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || lvd_reset)
        begin
            flag_mid_r <= 1'b0;
            flag_high_r <= 1'b0;
        end
        else
        begin
            flag_mid_r <= ((opt_r.lvd == MRC_supply_guard_mid)
                || (opt_r.lvd == MRC_supply_guard_high)) && lvd_s.below_2v4;
            flag_high_r <= (opt_r.lvd == MRC_supply_guard_high) && lvd_s.below_3v6;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            opt_r <= mrc_opt_s'(MRC_OPTION_RESET);
        else if (wr_option && (wstrb_r[1:0] == 2'h3))
            opt_r <= mrc_opt_s'(wdata_r[10:0]);
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    logic aw_held_r;
    logic w_held_r;

    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= MRC_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                awaddr_r <= {s_axi_awaddr[11:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= ((awaddr_r == MRC_ADDR_STATUS) || (awaddr_r == MRC_ADDR_OPTION))
                    ? MRC_RESP_OKAY : MRC_RESP_DECERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= MRC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= MRC_RESP_OKAY;
            if ({s_axi_araddr[11:2], 2'h0} == MRC_ADDR_STATUS)
                s_axi_rdata <= {24'h000000, status_rd};
            else if ({s_axi_araddr[11:2], 2'h0} == MRC_ADDR_OPTION)
                s_axi_rdata <= {21'h000000, opt_r};
            else
            begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= MRC_RESP_DECERR;
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule : mrc_top
`default_nettype wire

/* mrc_props.sv */
// concurrent checks on the reset and option block ports
`timescale 1ns/100ps
`default_nettype none
module mrc_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic supply_stable,
    input wire logic reset_pin,
    input wire logic system_reset,
    input wire logic pc_clear,
    input wire logic cpu_run,
    input wire logic cpu_cycle,
    input wire logic pin_port_bit,
    input wire logic pin_pullup_en
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // five edges cover the two-stage sync plus the registered reset
    sequence pin_held_low;
        (pin_pullup_en && !reset_pin)[*5];
    endsequence
    sequence quiet_after;
        (!cpu_cycle)[*3];
    endsequence

    a_run_inverse: assert property (cpu_run != system_reset)
        else $error("run and reset disagree");
    a_pc_cleared: assert property (pc_clear == system_reset)
        else $error("pc clear not tied to reset");
    a_supply_reset: assert property (!supply_stable |-> ##[1:4] system_reset)
        else $error("supply loss did not reset");
    a_release_stable: assert property ($fell(system_reset) |-> $past(supply_stable, 8))
        else $error("released before supply settled");
    a_cycle_gap: assert property (cpu_cycle |=> quiet_after)
        else $error("instruction cycles too close");
    a_pin_holds: assert property (pin_held_low |-> system_reset)
        else $error("low pin did not hold reset");
    a_pin_bit_zero: assert property (pin_pullup_en |-> !pin_port_bit)
        else $error("port bit live in reset mode");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
endmodule : mrc_props
`default_nettype wire

/* mrc_env.sv */
// far-side model: supply detectors, shared reset pin and oscillators
`timescale 1ns/100ps
`default_nettype none
module mrc_env
    import mrc_pkg::*;
(
    input wire logic aclk,
    input wire logic supply_ok,
    input wire logic pin_low,
    input wire logic [2:0] vdd_below,
    output logic supply_stable,
    output var mrc_lvd_s lvd_level,
    output logic reset_pin,
    output logic fast_osc_tick,
    output logic slow_osc_tick
);
    logic [1:0] fast_r = 2'h0;
    logic [2:0] slow_r = 3'h0;

    // ticks at least four clocks apart, so gaps scale with the divider
    always_ff @(posedge aclk)
    begin
        fast_r <= fast_r + 2'h1;
        slow_r <= (slow_r == 3'h4) ? 3'h0 : slow_r + 3'h1;
    end
    assign fast_osc_tick = (fast_r == 2'h3);
    assign slow_osc_tick = (slow_r == 3'h4);
    assign supply_stable = supply_ok;
    assign lvd_level = mrc_lvd_s'(vdd_below);
    assign reset_pin = !pin_low;
endmodule : mrc_env
`default_nettype wire

/* testbench.sv */
// self-checking bench for the reset and option block
`timescale 1ns/100ps
`default_nettype none
module testbench import mrc_pkg::*;;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, wdt_overflow = 1'h0;
    logic power_down_mode = 1'h0, green_mode = 1'h0, slow_mode = 1'h0;
    logic supply_ok = 1'h1, pin_low = 1'h0;
    logic [2:0] vdd_below = 3'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic supply_stable, reset_pin, fast_osc_tick, slow_osc_tick;
    mrc_lvd_s lvd_level;
    logic system_reset, pc_clear, cpu_run, cpu_cycle, wdt_count_en, rom_readout_block;
    logic pin_port_bit, pin_pullup_en, osc_in_pin_gpio, osc_out_pin_gpio;
    int fails = 0;
    int num_checks = 0;

    always #5 aclk = ~aclk;

    // short warm-up counts keep the run brief
    mrc_top #(.INIT_CYCLES(4), .WARM_RC_CYCLES(6), .WARM_XTAL_CYCLES(12)) uut (.*);
    mrc_env u_env (.aclk, .supply_ok, .pin_low, .vdd_below, .supply_stable,
        .lvd_level, .reset_pin, .fast_osc_tick, .slow_osc_tick);

    // ----------------------------------------
    // bus and helper tasks
    // ----------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task step(input int n);
        repeat (n) @(posedge aclk);
    endtask : step

    task axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] r);
        logic got;
        got = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (int k = 0; k < 50 && !got; k++)
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1)
                s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1)
            begin
                s_axi_bready <= 1'h0;
                r = s_axi_bresp;
                got = 1'h1;
            end
        end
        if (!got) fails++;
    endtask : axi_wr

    task axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic got;
        got = 1'h0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (int k = 0; k < 50 && !got; k++)
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'h1)
                s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1)
            begin
                s_axi_rready <= 1'h0;
                d = s_axi_rdata;
                r = s_axi_rresp;
                got = 1'h1;
            end
        end
        if (!got) fails++;
    endtask : axi_rd

    task set_opt(input logic [10:0] v);
        logic [1:0] r;
        axi_wr(MRC_ADDR_OPTION, {21'h0, v}, 4'h3, r);
        step(3);
    endtask : set_opt

    task wr_st(input logic [31:0] v);
        logic [1:0] r;
        axi_wr(MRC_ADDR_STATUS, v, 4'h1, r);
    endtask : wr_st

    task rd_st(input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(MRC_ADDR_STATUS, d, r);
        check(d & m, e);
    endtask : rd_st

    task wait_run;
        for (int k = 0; k < 300 && cpu_run !== 1'h1; k++)
            @(posedge aclk);
        check(32'(cpu_run), 32'h1);
    endtask : wait_run

    // third pass measures a whole gap with the new divider in force
    task meas(output logic [31:0] g);
        for (int k = 0; k < 3; k++)
        begin
            g = 32'h0;
            do
            begin
                @(posedge aclk);
                g++;
            end while (cpu_cycle !== 1'h1 && g < 32'hC8);
        end
    endtask : meas

    task wdt_reset(output logic [31:0] n);
        n = 32'h0;
        wdt_overflow <= 1'h1;
        step(1);
        wdt_overflow <= 1'h0;
        repeat (40)
        begin
            step(1);
            if (system_reset === 1'h1)
                n++;
        end
    endtask : wdt_reset

    task lvd_trip(input logic [2:0] v);
        vdd_below <= v;
        step(6);
        check(32'(system_reset), 32'h1);
        vdd_below <= 3'h0;
        wait_run();
    endtask : lvd_trip

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_regs;
        logic [31:0] d;
        logic [1:0] r;
        rd_st(32'hFF, 32'h80);
        wr_st(32'hFF);
        rd_st(32'hFF, 32'hC7);
        wr_st(32'h00);
        rd_st(32'hFF, 32'h00);
        axi_wr(12'h300, 32'h1, 4'hF, r);
        check(32'(r), 32'(MRC_RESP_DECERR));
        axi_rd(12'h300, d, r);
        check(d, 32'h0);
        check(32'(r), 32'(MRC_RESP_DECERR));
    endtask : t_regs

    task t_div;
        logic [31:0] g;
        for (int i = 0; i < 3; i++)
        begin
            set_opt(11'(i << 3));
            meas(g);
            check(g, 32'h10 << i);
        end
        slow_mode <= 1'h1;
        meas(g);
        check(g, 32'h14);
        slow_mode <= 1'h0;
    endtask : t_div

    task t_wdt;
        logic [31:0] n1;
        logic [31:0] n2;
        power_down_mode <= 1'h1;
        green_mode <= 1'h1;
        set_opt(11'h000);
        check(32'(wdt_count_en), 32'h1);
        set_opt(11'h020);
        check(32'(wdt_count_en), 32'h0);
        power_down_mode <= 1'h0;
        step(3);
        check(32'(wdt_count_en), 32'h0);
        green_mode <= 1'h0;
        step(3);
        check(32'(wdt_count_en), 32'h1);
        wr_st(32'h47);
        wdt_reset(n1);
        rd_st(32'hFF, 32'h00);
        set_opt(11'h023);
        wdt_reset(n2);
        check(n2 - n1, 32'h6);
        set_opt(11'h040);
        check(32'(wdt_count_en), 32'h0);
        wdt_reset(n1);
        check(n1, 32'h0);
    endtask : t_wdt

    task t_pin;
        set_opt(11'h000);
        check(32'(pin_pullup_en), 32'h1);
        wr_st(32'h07);
        pin_low <= 1'h1;
        step(30);
        check(32'(system_reset), 32'h1);
        pin_low <= 1'h0;
        wait_run();
        rd_st(32'hFF, 32'hC0);
        set_opt(11'h080);
        pin_low <= 1'h1;
        step(8);
        check({30'h0, pin_pullup_en, cpu_run}, 32'h1);
        check(32'(pin_port_bit), 32'h0);
        pin_low <= 1'h0;
        step(4);
        check(32'(pin_port_bit), 32'h1);
    endtask : t_pin

    task t_lvd;
        set_opt(11'h200);
        vdd_below <= 3'h6;
        step(4);
        rd_st(32'h30, 32'h10);
        check(32'(cpu_run), 32'h1);
        vdd_below <= 3'h0;
        step(4);
        rd_st(32'h30, 32'h00);
        set_opt(11'h400);
        vdd_below <= 3'h4;
        step(4);
        rd_st(32'h30, 32'h20);
        lvd_trip(3'h6);
        rd_st(32'hF0, 32'h80);
        set_opt(11'h600);
        lvd_trip(3'h4);
        set_opt(11'h000);
        vdd_below <= 3'h6;
        step(4);
        rd_st(32'h30, 32'h00);
        check(32'(cpu_run), 32'h1);
        vdd_below <= 3'h0;
        supply_ok <= 1'h0;
        step(4);
        check(32'(system_reset), 32'h1);
        supply_ok <= 1'h1;
        wait_run();
    endtask : t_lvd

    task t_opts;
        logic [1:0] exp [5] = '{2'h3, 2'h1, 2'h0, 2'h0, 2'h0};
        set_opt(11'h100);
        check(32'(rom_readout_block), 32'h1);
        for (int c = 0; c < 5; c++)
        begin
            set_opt(11'(c));
            check(32'({osc_in_pin_gpio, osc_out_pin_gpio}), 32'(exp[c]));
        end
        check(32'(rom_readout_block), 32'h0);
    endtask : t_opts

    task finish_test;
        $display("checks %0d errors %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    initial
    begin
        step(16);
        aresetn <= 1'h1;
        wait_run();
        t_regs();
        t_div();
        t_wdt();
        t_pin();
        t_lvd();
        t_opts();
        finish_test();
    end

    initial
    begin
        step(20000);
        fails++;
        finish_test();
    end
endmodule : testbench

bind mrc_top mrc_props u_props (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .supply_stable,
    .reset_pin, .system_reset, .pc_clear, .cpu_run, .cpu_cycle, .pin_port_bit,
    .pin_pullup_en);
`default_nettype wire
